// *** embedded_controller_flags_pkg.sv ***
package embedded_controller_flags_pkg;

    // Widths and depths
    localparam int BYTE_W       = 8;
    localparam int DATA_BYTES   = 4;
    localparam int FIFO_DEPTH   = 16;
    localparam int HOST_ADDR_W  = 3;
    localparam int EC_ADDR_W    = 9;

    // Host side offsets
    localparam logic [2:0] HOST_DATA0_OFF     = 3'h0;
    localparam logic [2:0] HOST_STATUS_OFF    = 3'h4;
    localparam logic [2:0] HOST_BYTE_CTRL_OFF = 3'h5;

    // Controller side offsets
    localparam logic [8:0] C2H_DATA0_OFF      = 9'h100;
    localparam logic [8:0] EC_STATUS_OFF      = 9'h104;
    localparam logic [8:0] EC_BYTE_CTRL_OFF   = 9'h105;
    localparam logic [8:0] H2C_DATA0_OFF      = 9'h108;

    // Field positions
    localparam int STATUS_CMD_BIT  = 3;
    localparam int STATUS_IBF_BIT  = 1;
    localparam int STATUS_OBF_BIT  = 0;
    localparam int FOUR_BYTE_BIT   = 0;

    // Byte that closes a transfer
    localparam logic [1:0] LAST_NARROW_IDX = 2'h0;
    localparam logic [1:0] LAST_WIDE_IDX   = 2'h3;

    // Reset values
    localparam logic       FLAG_RST      = 1'b0;
    localparam logic       FOUR_BYTE_RST = 1'b0;
    localparam logic [7:0] DATA_RST      = 8'h00;
    localparam logic [7:0] READ_ZERO     = 8'h00;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] data;
    } host_wr_type;

    typedef struct packed {
        logic input_full;
        logic output_full;
        logic cmd_pending;
        logic four_byte;
    } flags_type;

endpackage

// *** embedded_controller_buffer_flags.sv ***
`timescale 1ns/1ps

module byte_queue #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // Filling side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // Draining side
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PTR_W-1:0] wr_ptr_ff;
    logic [PTR_W-1:0] rd_ptr_ff;
    logic [PTR_W:0]   count_ff;
    logic [PTR_W:0]   nxt_count;
    logic             in_ready_ff;
    logic             out_valid_ff;
    logic             push;
    logic             pop;

    assign push      = in_valid & in_ready_ff;
    assign pop       = out_valid_ff & out_ready;
    assign nxt_count = count_ff + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    assign in_ready  = in_ready_ff;
    assign out_valid = out_valid_ff;
    assign out_data  = mem_ff[rd_ptr_ff];

    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_ff    <= '0;
            rd_ptr_ff    <= '0;
            count_ff     <= '0;
            in_ready_ff  <= 1'b1;
            out_valid_ff <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_ff <= wr_ptr_ff + PTR_W'(1);
            end
            if (pop)
            begin
                rd_ptr_ff <= rd_ptr_ff + PTR_W'(1);
            end
            count_ff     <= nxt_count;
            in_ready_ff  <= nxt_count != (PTR_W+1)'(DEPTH);
            out_valid_ff <= nxt_count != '0;
        end
    end

endmodule // byte_queue

module embedded_controller_buffer_flags (
    // Clock and reset
    input  wire logic                              clk_sys,
    input  wire logic                              rst,
    // Host write queue
    input  wire logic                              host_wr_valid,
    input  wire embedded_controller_flags_pkg::host_wr_type    host_wr_req,
    output logic                                   host_wr_ready,
    // Host reads
    input  wire logic                              host_rd_en,
    input  wire logic [2:0]                        host_rd_addr,
    output logic [7:0]                             host_rd_data,
    // Controller registers
    input  wire logic                              ec_wr_en,
    input  wire logic                              ec_rd_en,
    input  wire logic [8:0]                        ec_addr,
    input  wire logic [7:0]                        ec_wdata,
    output logic [7:0]                             ec_rdata,
    // Events and state toward the controller
    output logic                                   irq_input_full,
    output logic                                   irq_output_full,
    output embedded_controller_flags_pkg::flags_type           flags
);
    import embedded_controller_flags_pkg::*;

    function automatic logic is_last_byte(input logic       wide,
                                          input logic [1:0] idx);
        return wide ? (idx == LAST_WIDE_IDX) : (idx == LAST_NARROW_IDX);
    endfunction

    function automatic logic [7:0] status_byte(input logic cmd,
                                               input logic input_full_flag,
                                               input logic output_full_flag);
        logic [7:0] s;
        s = '0;
        s[STATUS_CMD_BIT] = cmd;
        s[STATUS_IBF_BIT] = input_full_flag;
        s[STATUS_OBF_BIT] = output_full_flag;
        return s;
    endfunction

    logic [7:0]  h2c_ff [DATA_BYTES];
    logic [7:0]  c2h_ff [DATA_BYTES];
    logic        input_full_ff;
    logic        output_full_ff;
    logic        cmd_pending_ff;
    logic        four_byte_ff;
    logic [7:0]  host_rd_data_ff;
    logic [7:0]  ec_rdata_ff;
    logic        irq_input_full_ff;
    logic        irq_output_full_ff;
    logic [7:0]  nxt_host_rd_data;
    logic [7:0]  nxt_ec_rdata;

    host_wr_type drain_req;
    logic        drain_valid;
    logic        drain_ready;
    logic        drain_fire;
    logic        host_cmd_wr;
    logic        host_data_wr;
    logic [1:0]  data_idx;
    logic [1:0]  ec_idx;
    logic [1:0]  host_idx;
    logic        ec_h2c_rd;
    logic        ec_c2h_wr;
    logic        host_data_rd;
    logic        ibf_set;
    logic        ibf_clr;
    logic        obf_set;
    logic        obf_clr;

    byte_queue #(
        .WIDTH ($bits(host_wr_type)),
        .DEPTH (FIFO_DEPTH)
    ) u_host_queue (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (host_wr_valid),
        .in_data   (host_wr_req),
        .in_ready  (host_wr_ready),
        .out_valid (drain_valid),
        .out_data  (drain_req),
        .out_ready (drain_ready)
    );

    // Hold queued host writes until the controller took the last message
    assign drain_ready  = ~input_full_ff;
    assign drain_fire   = drain_valid & drain_ready;
    assign data_idx     = drain_req.addr[1:0];
    assign host_cmd_wr  = drain_fire & (drain_req.addr == HOST_STATUS_OFF);
    assign host_data_wr = drain_fire
                        & (drain_req.addr[2] == HOST_DATA0_OFF[2]);

    assign ec_idx    = ec_addr[1:0];
    assign ec_h2c_rd = ec_rd_en & (ec_addr[8:2] == H2C_DATA0_OFF[8:2]);
    assign ec_c2h_wr = ec_wr_en & (ec_addr[8:2] == C2H_DATA0_OFF[8:2]);

    assign host_idx     = host_rd_addr[1:0];
    assign host_data_rd = host_rd_en
                        & (host_rd_addr[2] == HOST_DATA0_OFF[2]);

    assign ibf_set = host_cmd_wr
                   | (host_data_wr
                      & is_last_byte(four_byte_ff, data_idx));
    assign ibf_clr = ec_h2c_rd
                   & (cmd_pending_ff
                      ? (ec_idx == LAST_NARROW_IDX)
                      : is_last_byte(four_byte_ff, ec_idx));
    assign obf_set = ec_c2h_wr
                   & is_last_byte(four_byte_ff, ec_idx);
    assign obf_clr = host_data_rd
                   & is_last_byte(four_byte_ff, host_idx);

    // Command byte lands in byte 0, data bytes at their index
    for (genvar i = 0; i < DATA_BYTES; i++)
    begin : g_bytes
        always_ff @(posedge clk_sys or posedge rst)
        begin
            if (rst)
            begin
                h2c_ff[i] <= DATA_RST;
            end
            else if ((host_cmd_wr && i == 0)
                     || (host_data_wr && data_idx == 2'(i)))
            begin
                h2c_ff[i] <= drain_req.data;
            end
        end

        always_ff @(posedge clk_sys or posedge rst)
        begin
            if (rst)
            begin
                c2h_ff[i] <= DATA_RST;
            end
            else if (ec_c2h_wr && ec_idx == 2'(i))
            begin
                c2h_ff[i] <= ec_wdata;
            end
        end
    end

    // Handshake flags, set wins over clear
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            input_full_ff  <= FLAG_RST;
            output_full_ff <= FLAG_RST;
            cmd_pending_ff <= FLAG_RST;
        end
        else
        begin
            input_full_ff  <= ibf_set | (input_full_ff & ~ibf_clr);
            output_full_ff <= obf_set | (output_full_ff & ~obf_clr);
            if (host_cmd_wr)
            begin
                cmd_pending_ff <= 1'b1;
            end
            else if (host_data_wr)
            begin
                cmd_pending_ff <= 1'b0;
            end
        end
    end

    // Byte mode is writable by the controller only
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            four_byte_ff <= FOUR_BYTE_RST;
        end
        else if (ec_wr_en && ec_addr == EC_BYTE_CTRL_OFF)
        begin
            four_byte_ff <= ec_wdata[FOUR_BYTE_BIT];
        end
    end

    // Interrupt pulses toward the controller
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            irq_input_full_ff  <= 1'b0;
            irq_output_full_ff <= 1'b0;
        end
        else
        begin
            irq_input_full_ff  <= ibf_set & ~input_full_ff;
            irq_output_full_ff <= obf_clr & ~obf_set
                                & output_full_ff;
        end
    end

    always_comb
    begin
        nxt_ec_rdata = READ_ZERO;
        if (ec_addr[8:2] == H2C_DATA0_OFF[8:2])
        begin
            if (four_byte_ff || ec_idx == LAST_NARROW_IDX)
            begin
                nxt_ec_rdata = h2c_ff[ec_idx];
            end
            else
            begin
                nxt_ec_rdata = READ_ZERO;
            end
        end
        else if (ec_addr[8:2] == C2H_DATA0_OFF[8:2])
        begin
            nxt_ec_rdata = c2h_ff[ec_idx];
        end
        else if (ec_addr == EC_STATUS_OFF)
        begin
            nxt_ec_rdata = status_byte(cmd_pending_ff, input_full_ff,
                                       output_full_ff);
        end
        else if (ec_addr == EC_BYTE_CTRL_OFF)
        begin
            nxt_ec_rdata[FOUR_BYTE_BIT] = four_byte_ff;
        end
    end

    always_comb
    begin
        nxt_host_rd_data = READ_ZERO;
        case (host_rd_addr)
            HOST_STATUS_OFF:
                nxt_host_rd_data = status_byte(cmd_pending_ff,
                                               input_full_ff,
                                               output_full_ff);
            HOST_BYTE_CTRL_OFF:
                nxt_host_rd_data[FOUR_BYTE_BIT] = four_byte_ff;
            default:
            begin
                if (host_data_rd
                    && (four_byte_ff || host_idx == LAST_NARROW_IDX))
                begin
                    nxt_host_rd_data = c2h_ff[host_idx];
                end
            end
        endcase
    end

    // Read data registered, held between reads
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            host_rd_data_ff <= READ_ZERO;
            ec_rdata_ff     <= READ_ZERO;
        end
        else
        begin
            if (host_rd_en)
            begin
                host_rd_data_ff <= nxt_host_rd_data;
            end
            if (ec_rd_en)
            begin
                ec_rdata_ff <= nxt_ec_rdata;
            end
        end
    end

    assign host_rd_data      = host_rd_data_ff;
    assign ec_rdata          = ec_rdata_ff;
    assign irq_input_full    = irq_input_full_ff;
    assign irq_output_full   = irq_output_full_ff;
    assign flags.input_full  = input_full_ff;
    assign flags.output_full = output_full_ff;
    assign flags.cmd_pending = cmd_pending_ff;
    assign flags.four_byte   = four_byte_ff;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_obf_drained;
        output_full_ff && obf_clr && !obf_set;
    endsequence

    sequence s_irq_pulse;
        irq_output_full ##1 !irq_output_full;
    endsequence

    a_cmd_sets_flags: assert property (
        host_cmd_wr |=> input_full_ff && cmd_pending_ff)
        else $error("command write did not set both flags");

    a_cmd_read_clear: assert property (
        ec_h2c_rd && cmd_pending_ff && ec_idx == 2'h0 && !ibf_set
        |=> !input_full_ff)
        else $error("command byte read did not clear input full");

    a_narrow_data_set: assert property (
        host_data_wr && !four_byte_ff && data_idx == 2'h0
        |=> input_full_ff && !cmd_pending_ff)
        else $error("narrow data write flags wrong");

    a_wide_data_set: assert property (
        host_data_wr && four_byte_ff && data_idx == 2'h3
        |=> input_full_ff && !cmd_pending_ff)
        else $error("wide data write flags wrong");

    a_narrow_read_clear: assert property (
        ec_h2c_rd && !cmd_pending_ff && !four_byte_ff && ec_idx == 2'h0
        && !ibf_set |=> !input_full_ff)
        else $error("narrow read did not clear input full");

    a_wide_read_clear: assert property (
        ec_h2c_rd && !cmd_pending_ff && four_byte_ff && ec_idx == 2'h3
        && !ibf_set |=> !input_full_ff)
        else $error("wide read did not clear input full");

    a_wide_early_hold: assert property (
        ec_h2c_rd && !cmd_pending_ff && four_byte_ff && ec_idx != 2'h3
        && input_full_ff |=> input_full_ff)
        else $error("early wide read cleared input full");

    a_ibf_irq_pulse: assert property (
        $rose(input_full_ff) |-> irq_input_full ##1 !irq_input_full)
        else $error("input full interrupt not pulsed");

    a_obf_set_event: assert property (
        ec_wr_en && ec_addr == (four_byte_ff ? 9'h103 : 9'h100)
        |=> output_full_ff)
        else $error("reply write did not set output full");

    a_obf_clear_read: assert property (
        host_rd_en && host_rd_addr == (four_byte_ff ? 3'h3 : 3'h0)
        && !obf_set |=> !output_full_ff)
        else $error("host read did not clear output full");

    a_obf_irq_pulse: assert property (
        s_obf_drained |=> s_irq_pulse)
        else $error("output full interrupt not pulsed");

    a_narrow_zero_read: assert property (
        ec_h2c_rd && !four_byte_ff && ec_idx != 2'h0 |=> ec_rdata == 8'h00)
        else $error("narrow upper byte read not zero");

endmodule // embedded_controller_buffer_flags

// *** host_os_model.sv ***
`timescale 1ns/1ps

module host_os_model (
    // Clock
    input  wire logic                      clk_sys,
    // Host write queue
    output logic                           host_wr_valid,
    output embedded_controller_flags_pkg::host_wr_type host_wr_req,
    input  wire logic                      host_wr_ready,
    // Host reads
    output logic                           host_rd_en,
    output logic [2:0]                     host_rd_addr,
    input  wire logic [7:0]                host_rd_data
);
    import embedded_controller_flags_pkg::*;

    initial
    begin
        host_wr_valid = 1'b0;
        host_wr_req   = '0;
        host_rd_en    = 1'b0;
        host_rd_addr  = 3'h0;
    end

    // Held until the queue takes it
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        host_wr_valid <= 1'b1;
        host_wr_req   <= {a, d};
        do @(posedge clk_sys); while (host_wr_ready !== 1'b1);
        host_wr_valid <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        host_rd_en   <= 1'b1;
        host_rd_addr <= a;
        @(posedge clk_sys);
        host_rd_en   <= 1'b0;
        #1;
        d = host_rd_data;
    endtask

    // Status poll, then every reply byte if output full is set
    task automatic poll(input logic wide, output logic [31:0] reply);
        logic [7:0] s;
        logic [7:0] b;
        reply = 32'h0;
        rd(HOST_STATUS_OFF, s);
        if (s[STATUS_OBF_BIT])
            for (int i = 0; i <= (wide ? 3 : 0); i++)
            begin
                rd(3'(i), b);
                reply[8*i +: 8] = b;
            end
    endtask
endmodule // host_os_model

// *** tb.sv ***
`timescale 1ns/1ps

module tb;
    import embedded_controller_flags_pkg::*;

    logic        clk_sys  = 1'b0;
    logic        rst      = 1'b1;
    logic        ec_wr_en = 1'b0;
    logic        ec_rd_en = 1'b0;
    logic [8:0]  ec_addr  = 9'h000;
    logic [7:0]  ec_wdata = 8'h00;
    logic        host_wr_valid;
    logic        host_wr_ready;
    host_wr_type host_wr_req;
    logic        host_rd_en;
    logic [2:0]  host_rd_addr;
    logic [7:0]  host_rd_data;
    logic [7:0]  ec_rdata;
    logic [7:0]  d;
    logic [31:0] r;
    logic        irq_input_full;
    logic        irq_output_full;
    flags_type   flags;
    int          num_errors = 0;
    int          n_tests    = 0;
    int          n_iif      = 0;
    int          n_iof      = 0;

    always #2 clk_sys = ~clk_sys;

    embedded_controller_buffer_flags i_dut (
        .clk_sys(clk_sys), .rst(rst),
        .host_wr_valid(host_wr_valid), .host_wr_req(host_wr_req),
        .host_wr_ready(host_wr_ready), .host_rd_en(host_rd_en),
        .host_rd_addr(host_rd_addr), .host_rd_data(host_rd_data),
        .ec_wr_en(ec_wr_en), .ec_rd_en(ec_rd_en), .ec_addr(ec_addr),
        .ec_wdata(ec_wdata), .ec_rdata(ec_rdata),
        .irq_input_full(irq_input_full),
        .irq_output_full(irq_output_full), .flags(flags)
    );

    host_os_model i_host (
        .clk_sys(clk_sys), .host_wr_valid(host_wr_valid),
        .host_wr_req(host_wr_req), .host_wr_ready(host_wr_ready),
        .host_rd_en(host_rd_en), .host_rd_addr(host_rd_addr),
        .host_rd_data(host_rd_data)
    );

    // Pulse counters, one count per high cycle
    always @(posedge clk_sys)
    begin
        if (irq_input_full === 1'b1) n_iif++;
        if (irq_output_full === 1'b1) n_iof++;
    end

    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Order: input full, output full, command pending
    task automatic chkf(input logic [2:0] exp);
        chk("flags", {5'h00, flags.input_full, flags.output_full,
                      flags.cmd_pending}, {5'h00, exp});
    endtask

    task automatic ec_wr(input logic [8:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        ec_wr_en <= 1'b1;
        ec_addr  <= a;
        ec_wdata <= v;
        @(posedge clk_sys);
        ec_wr_en <= 1'b0;
        #1;
    endtask

    task automatic ec_rd(input logic [8:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        ec_rd_en <= 1'b1;
        ec_addr  <= a;
        @(posedge clk_sys);
        ec_rd_en <= 1'b0;
        #1;
        v = ec_rdata;
    endtask

    // Queue latency when empty
    task automatic hwait();
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        #20000;
        num_errors++;
        stop_test();
    end

    initial
    begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chkf(3'b000);
        i_host.rd(HOST_STATUS_OFF, d);
        chk("host status", d, 8'h00);
        i_host.wr(3'h5, 8'h01);
        hwait();
        ec_rd(EC_BYTE_CTRL_OFF, d);
        chk("mode", d, 8'h00);
        $display("done: reset");

        i_host.wr(HOST_STATUS_OFF, 8'hA5);
        hwait();
        chkf(3'b101);
        chk("irq in", 8'(n_iif), 8'h01);
        ec_rd(H2C_DATA0_OFF, d);
        chk("cmd byte", d, 8'hA5);
        chkf(3'b001);
        i_host.wr(HOST_DATA0_OFF, 8'h3C);
        hwait();
        chkf(3'b100);
        ec_rd(9'h109, d);
        chk("narrow b1", d, 8'h00);
        chkf(3'b100);
        ec_rd(H2C_DATA0_OFF, d);
        chk("data byte", d, 8'h3C);
        chkf(3'b000);
        chk("irq in", 8'(n_iif), 8'h02);
        ec_wr(9'h101, 8'h77);
        chkf(3'b000);
        ec_wr(C2H_DATA0_OFF, 8'h5A);
        chkf(3'b010);
        i_host.poll(1'b0, r);
        chk("reply", r[7:0], 8'h5A);
        chkf(3'b000);
        // Pulse is counted at the edge after the clearing read
        @(posedge clk_sys);
        #1;
        chk("irq out", 8'(n_iof), 8'h01);
        $display("done: narrow");

        ec_wr(EC_BYTE_CTRL_OFF, 8'h01);
        chk("mode flag", {7'h00, flags.four_byte}, 8'h01);
        i_host.wr(HOST_STATUS_OFF, 8'h81);
        hwait();
        chkf(3'b101);
        ec_rd(H2C_DATA0_OFF, d);
        chkf(3'b001);
        for (int i = 0; i < 3; i++)
            i_host.wr(3'(i), 8'h10 + 8'(i));
        hwait();
        chkf(3'b000);
        i_host.wr(3'h3, 8'h13);
        hwait();
        chkf(3'b100);
        for (int i = 0; i < 3; i++)
        begin
            ec_rd(H2C_DATA0_OFF + 9'(i), d);
            chk("wide byte", d, 8'h10 + 8'(i));
        end
        chkf(3'b100);
        ec_rd(9'h10B, d);
        chk("wide b3", d, 8'h13);
        chkf(3'b000);
        for (int i = 0; i < 3; i++)
            ec_wr(C2H_DATA0_OFF + 9'(i), 8'hC0 + 8'(i));
        chkf(3'b000);
        ec_wr(9'h103, 8'hC3);
        chkf(3'b010);
        i_host.rd(HOST_DATA0_OFF, d);
        chkf(3'b010);
        i_host.poll(1'b1, r);
        chk("reply b0", r[7:0], 8'hC0);
        chk("reply b3", r[31:24], 8'hC3);
        chkf(3'b000);
        @(posedge clk_sys);
        #1;
        chk("irq out", 8'(n_iof), 8'h02);
        chk("irq in", 8'(n_iif), 8'h04);
        $display("done: wide");
        stop_test();
    end
endmodule // tb
